// [src/lhb_pkg.sv]
// Package for the local bus hold bridge: widths, states and carriers
package lhb_pkg;
  // ****************************************************************
  // Bus widths
  // ****************************************************************
  localparam int SYS_ADDR_W = 32;
  localparam int SYS_DATA_W = 64;
  localparam int LOC_ADDR_W = 32;
  localparam int LOC_DATA_W = 32;
  localparam int BE_W       = 8;
  localparam int LOC_BE_W   = 4;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic RST_HOLD_REQ = 1'b0;
  localparam logic RST_HOLD_ACK = 1'b0;

  // ****************************************************************
  // Hold relay states, Gray along the usual path
  // ****************************************************************
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_REQ  = 2'b01,
    HS_HELD = 2'b11,
    HS_DROP = 2'b10
  } lhb_hold_state_t;

  // Word-sequencer states for a 64-bit access over the 32-bit bus
  typedef enum logic [1:0] {
    WS_IDLE = 2'b00,
    WS_LOW  = 2'b01,
    WS_HIGH = 2'b11,
    WS_DONE = 2'b10
  } lhb_word_state_t;

  // Processor-side request toward the local bus
  typedef struct packed {
    logic                  valid;
    logic                  write;
    logic [SYS_ADDR_W-1:0] addr;
    logic [SYS_DATA_W-1:0] wdata;
    logic [BE_W-1:0]       be;
  } lhb_sys_req_t;

  // Local-bus cycle toward the devices
  typedef struct packed {
    logic                  valid;
    logic                  write;
    logic [LOC_ADDR_W-1:0] addr;
    logic [LOC_DATA_W-1:0] wdata;
    logic [LOC_BE_W-1:0]   be;
  } lhb_loc_req_t;

  // Local master request toward the memory controller
  typedef struct packed {
    logic                  valid;
    logic                  write;
    logic [SYS_ADDR_W-1:0] addr;
    logic [SYS_DATA_W-1:0] wdata;
    logic [BE_W-1:0]       be;
  } lhb_mem_req_t;
endpackage

// [src/lhb_bridge.sv]
// Local bus hold bridge: hold relay plus access paths both ways
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - System side carries 32-bit address, 64-bit data.
// - Local bus is 32/32; wide transfers narrowed.
// - Processor owns both buses unless hold granted.
// - Local hold request raises hold toward processor.
// - Processor answers with hold grant.
// - Acknowledge local device only after grant.
// - Relay processor-to-local and local-to-memory accesses.
// - Suffix B means active low; unsuffixed pins are active high.
// - Hold waits while transaction start enable asserted.
// - Grant means processor released the system bus.
module lhb_bridge (
  input  wire logic                           CLK_IN,
  input  wire logic                           RST_B_IN,
  input  wire logic                           LOC_HOLD_REQ_B_IN,
  output logic                                LOC_HOLD_ACK_B_OUT,
  output logic                                HOLD_REQUEST_TO_CPU_B_OUT,
  input  wire logic                           HOLD_GRANT_FROM_CPU_B_IN,
  input  wire logic                           TRANSACTION_START_ENABLE_B_IN,
  input  wire lhb_pkg::lhb_sys_req_t          SYS_REQ_IN,
  output logic                                SYS_RDY_OUT,
  output logic [lhb_pkg::SYS_DATA_W-1:0]      SYS_RDATA_OUT,
  output lhb_pkg::lhb_loc_req_t               LOC_REQ_OUT,
  input  wire logic                           LOC_RDY_IN,
  input  wire logic [lhb_pkg::LOC_DATA_W-1:0] LOC_RDATA_IN,
  input  wire lhb_pkg::lhb_mem_req_t          LOC_MST_REQ_IN,
  output logic                                LOC_MST_RDY_OUT,
  output logic [lhb_pkg::SYS_DATA_W-1:0]      LOC_MST_RDATA_OUT,
  output lhb_pkg::lhb_mem_req_t               MEM_REQ_OUT,
  input  wire logic                           MEM_RDY_IN,
  input  wire logic [lhb_pkg::SYS_DATA_W-1:0] MEM_RDATA_IN
);
  import lhb_pkg::*;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic loc_hreq_s1_q, loc_hreq_s2_q;
  logic grant_s1_q, grant_s2_q;
  logic tse_s1_q, tse_s2_q;

  // Only the second stage is read by the logic below
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      {loc_hreq_s1_q, loc_hreq_s2_q} <= 2'b00;
      {grant_s1_q, grant_s2_q}       <= 2'b00;
      {tse_s1_q, tse_s2_q}           <= 2'b00;
    end else begin
      loc_hreq_s1_q <= ~LOC_HOLD_REQ_B_IN;
      loc_hreq_s2_q <= loc_hreq_s1_q;
      grant_s1_q    <= ~HOLD_GRANT_FROM_CPU_B_IN;
      grant_s2_q    <= grant_s1_q;
      tse_s1_q      <= ~TRANSACTION_START_ENABLE_B_IN;
      tse_s2_q      <= tse_s1_q;
    end
  end

  // ****************************************************************
  // Hold relay
  // ****************************************************************
  lhb_hold_state_t hold_q, hold_d;
  logic            cpu_req_q, cpu_req_d;
  logic            ack_q, ack_d;
  wire             loc_wants  = loc_hreq_s2_q;
  wire             cpu_grant  = grant_s2_q;
  wire             tse_active = tse_s2_q;

  // Next-state: request, wait for grant, hold, then release
  always_comb begin
    hold_d    = hold_q;
    cpu_req_d = cpu_req_q;
    ack_d     = ack_q;
    unique case (hold_q)
      HS_IDLE: begin
        // A hold is only started while start enable is inactive; HS_REQ does not check it
        if (loc_wants && !tse_active) begin
          hold_d    = HS_REQ;
          cpu_req_d = 1'b1;
        end
      end
      HS_REQ: begin
        if (!loc_wants) begin
          hold_d    = HS_IDLE;
          cpu_req_d = 1'b0;
        end else if (cpu_grant) begin
          hold_d = HS_HELD;
          ack_d  = 1'b1;
        end
      end
      HS_HELD: begin
        if (!loc_wants) begin
          hold_d    = HS_DROP;
          ack_d     = 1'b0;
          cpu_req_d = 1'b0;
        end
      end
      HS_DROP: begin
        // Wait for the processor to retake the bus
        if (!cpu_grant) begin
          hold_d = HS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      hold_q    <= HS_IDLE;
      cpu_req_q <= RST_HOLD_REQ;
      ack_q     <= RST_HOLD_ACK;
    end else begin
      hold_q    <= hold_d;
      cpu_req_q <= cpu_req_d;
      ack_q     <= ack_d;
    end
  end

  assign HOLD_REQUEST_TO_CPU_B_OUT = ~cpu_req_q;
  assign LOC_HOLD_ACK_B_OUT        = ~ack_q;

  // Local master owns the system bus only in the held state
  wire loc_owns = (hold_q == HS_HELD) && cpu_grant;
  wire cpu_owns = ~loc_owns;

  // ****************************************************************
  // Processor to local bus: 64-bit split into two 32-bit words
  // ****************************************************************
  lhb_word_state_t ws_q, ws_d;
  lhb_loc_req_t    lreq_q, lreq_d;
  logic [SYS_DATA_W-1:0] rdata_q, rdata_d;
  wire             need_low  = |SYS_REQ_IN.be[LOC_BE_W-1:0];
  wire             need_high = |SYS_REQ_IN.be[BE_W-1:LOC_BE_W];
  wire             go        = SYS_REQ_IN.valid && cpu_owns;

  // Low word first unless only high lanes are enabled, then high word when its lanes are enabled
  always_comb begin
    ws_d    = ws_q;
    lreq_d  = lreq_q;
    rdata_d = rdata_q;
    unique case (ws_q)
      WS_IDLE: begin
        if (go) begin
          lreq_d.valid = 1'b1;
          lreq_d.write = SYS_REQ_IN.write;
          if (need_low || !need_high) begin
            ws_d         = WS_LOW;
            lreq_d.addr  = {SYS_REQ_IN.addr[SYS_ADDR_W-1:3], 3'h0};
            lreq_d.wdata = SYS_REQ_IN.wdata[LOC_DATA_W-1:0];
            lreq_d.be    = SYS_REQ_IN.be[LOC_BE_W-1:0];
          end else begin
            ws_d         = WS_HIGH;
            lreq_d.addr  = {SYS_REQ_IN.addr[SYS_ADDR_W-1:3], 3'h4};
            lreq_d.wdata = SYS_REQ_IN.wdata[SYS_DATA_W-1:LOC_DATA_W];
            lreq_d.be    = SYS_REQ_IN.be[BE_W-1:LOC_BE_W];
          end
        end
      end
      WS_LOW: begin
        if (LOC_RDY_IN) begin
          rdata_d[LOC_DATA_W-1:0] = LOC_RDATA_IN;
          if (need_high) begin
            ws_d         = WS_HIGH;
            lreq_d.addr  = {SYS_REQ_IN.addr[SYS_ADDR_W-1:3], 3'h4};
            lreq_d.wdata = SYS_REQ_IN.wdata[SYS_DATA_W-1:LOC_DATA_W];
            lreq_d.be    = SYS_REQ_IN.be[BE_W-1:LOC_BE_W];
          end else begin
            ws_d         = WS_DONE;
            lreq_d.valid = 1'b0;
          end
        end
      end
      WS_HIGH: begin
        if (LOC_RDY_IN) begin
          rdata_d[SYS_DATA_W-1:LOC_DATA_W] = LOC_RDATA_IN;
          ws_d         = WS_DONE;
          lreq_d.valid = 1'b0;
        end
      end
      WS_DONE: begin
        ws_d = WS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      ws_q    <= WS_IDLE;
      lreq_q  <= '0;
      rdata_q <= '0;
    end else begin
      ws_q    <= ws_d;
      lreq_q  <= lreq_d;
      rdata_q <= rdata_d;
    end
  end

  assign LOC_REQ_OUT   = lreq_q;
  assign SYS_RDY_OUT   = (ws_q == WS_DONE);
  assign SYS_RDATA_OUT = rdata_q;

  // ****************************************************************
  // Local master to memory controller, gated by ownership
  // ****************************************************************
  // Combinational pass adds no cycle of latency to the handshake
  assign MEM_REQ_OUT.valid   = LOC_MST_REQ_IN.valid && loc_owns;
  assign MEM_REQ_OUT.write   = LOC_MST_REQ_IN.write;
  assign MEM_REQ_OUT.addr    = LOC_MST_REQ_IN.addr;
  assign MEM_REQ_OUT.wdata   = LOC_MST_REQ_IN.wdata;
  assign MEM_REQ_OUT.be      = LOC_MST_REQ_IN.be;
  assign LOC_MST_RDY_OUT     = MEM_RDY_IN && loc_owns;
  assign LOC_MST_RDATA_OUT   = MEM_RDATA_IN;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_ack_needs_grant: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    $rose(ack_q) |-> $past(cpu_grant) && cpu_req_q)
    else $error("acknowledge raised without grant");
  chk_req_follows_loc: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    (hold_q == HS_IDLE && loc_wants && !tse_active) |=> cpu_req_q)
    else $error("hold request not relayed");
  chk_tse_blocks_hold: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    (hold_q == HS_IDLE && tse_active) |=> !cpu_req_q)
    else $error("hold broke a start-enabled sequence");
  chk_release_drops: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    (hold_q == HS_HELD && !loc_wants) |=> !ack_q && !cpu_req_q)
    else $error("withdrawn request not released");
  chk_cpu_owns_idle: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    !ack_q |-> !MEM_REQ_OUT.valid)
    else $error("memory access without hold");
  chk_loc_quiet_held: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    (loc_owns && ws_q == WS_IDLE) |=> ws_q == WS_IDLE)
    else $error("processor access while bus held");
  chk_word_split: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    (ws_q == WS_LOW && LOC_RDY_IN && need_high) |=> ws_q == WS_HIGH && lreq_q.addr[2])
    else $error("high word not issued");
  chk_rdy_one_cycle: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    SYS_RDY_OUT |=> !SYS_RDY_OUT)
    else $error("ready longer than one cycle");
endmodule

`default_nettype wire

// [dv/lhb_far_model.sv]
// Far-side model: processor hold grant and a local-bus word slave
`timescale 1ns/1ps
`default_nettype none
module lhb_far_model (
  input  wire logic                 clk_in,
  input  wire logic                 rst_b_in,
  input  wire logic                 slow_in,
  input  wire logic                 hold_req_b_in,
  input  wire lhb_pkg::lhb_loc_req_t loc_req_in,
  output logic                      grant_b_out,
  output logic                      rdy_out,
  output logic [31:0]               rdata_out
);
  import lhb_pkg::*;
  logic [3:0] wait_q;
  // ****
  // Grant lags request; slave word answers
  // ****
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      grant_b_out <= 1'b1;
      rdy_out <= 1'b0;
      rdata_out <= 32'h0;
      wait_q <= 4'h0;
    end else begin
      grant_b_out <= hold_req_b_in;
      rdy_out <= 1'b0;
      // Idle data toggles so a stale word never matches
      rdata_out <= ~rdata_out;
      if (loc_req_in.valid && !rdy_out) begin
        if (wait_q == (slow_in ? 4'h5 : 4'h0)) begin
          rdy_out <= 1'b1;
          rdata_out <= loc_req_in.addr ^ 32'h5a5a_a5a5;
          wait_q <= 4'h0;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [dv/tb.sv]
// Testbench: hold relay, word splitting and memory gating
`timescale 1ns/1ps
`default_nettype none
module tb;
  import lhb_pkg::*;
  logic CLK_IN = 1'b0, RST_B_IN = 1'b0, LOC_HOLD_REQ_B_IN = 1'b1, TSE_B = 1'b1, slow = 1'b0;
  logic MEM_RDY_IN = 1'b0, LOC_RDY_IN, GRANT_B, SYS_RDY_OUT, LOC_MST_RDY_OUT, ACK_B, CPU_B;
  logic [63:0] SYS_RDATA_OUT, LOC_MST_RDATA_OUT, MEM_RDATA_IN = 64'h0;
  logic [31:0] LOC_RDATA_IN, seed = 32'h5, mr;
  lhb_sys_req_t SYS_REQ_IN = '0;
  lhb_loc_req_t LOC_REQ_OUT;
  lhb_mem_req_t LOC_MST_REQ_IN = '0, MEM_REQ_OUT;
  int fail_count = 0, checked = 0;
  logic [64:0] notes[$], note;
  logic        mid = 1'b0, exp_hi;

  always #4 CLK_IN = ~CLK_IN;

  lhb_bridge u_dut (.CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .LOC_HOLD_REQ_B_IN(LOC_HOLD_REQ_B_IN),
    .LOC_HOLD_ACK_B_OUT(ACK_B), .HOLD_REQUEST_TO_CPU_B_OUT(CPU_B), .HOLD_GRANT_FROM_CPU_B_IN(GRANT_B),
    .TRANSACTION_START_ENABLE_B_IN(TSE_B), .SYS_REQ_IN(SYS_REQ_IN), .SYS_RDY_OUT(SYS_RDY_OUT),
    .SYS_RDATA_OUT(SYS_RDATA_OUT), .LOC_REQ_OUT(LOC_REQ_OUT), .LOC_RDY_IN(LOC_RDY_IN),
    .LOC_RDATA_IN(LOC_RDATA_IN), .LOC_MST_REQ_IN(LOC_MST_REQ_IN), .LOC_MST_RDY_OUT(LOC_MST_RDY_OUT),
    .LOC_MST_RDATA_OUT(LOC_MST_RDATA_OUT), .MEM_REQ_OUT(MEM_REQ_OUT), .MEM_RDY_IN(MEM_RDY_IN),
    .MEM_RDATA_IN(MEM_RDATA_IN));
  lhb_far_model u_far (.clk_in(CLK_IN), .rst_b_in(RST_B_IN), .slow_in(slow), .hold_req_b_in(CPU_B),
    .loc_req_in(LOC_REQ_OUT), .grant_b_out(GRANT_B), .rdy_out(LOC_RDY_IN), .rdata_out(LOC_RDATA_IN));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Bounded wait on a hold output; a miss shows as a mismatch
  task automatic wait_lvl(input logic ack_sel, input logic v);
    int n;
    n = 0;
    while ((ack_sel ? ACK_B : CPU_B) !== v && n < 40) begin
      @(negedge CLK_IN);
      n++;
    end
    check(ack_sel ? ACK_B : CPU_B, v);
  endtask

  // Processor access; read data note built from the slave's rule
  task automatic sys_access(input logic wr, input logic [31:0] a, input logic [7:0] be);
    logic [31:0] lo;
    int n;
    lo = {a[31:3], 3'b000};
    notes.push_back({~wr, (lo + 32'h4) ^ 32'h5a5a_a5a5, lo ^ 32'h5a5a_a5a5});
    SYS_REQ_IN <= '{1'b1, wr, a, {rnd(), rnd()}, be};
    n = 0;
    do begin
      @(negedge CLK_IN);
      n++;
    end while (SYS_RDY_OUT !== 1'b1 && n < 60);
    if (SYS_RDY_OUT !== 1'b1) check(SYS_RDY_OUT, 1'b1);
    SYS_REQ_IN.valid <= 1'b0;
    @(negedge CLK_IN);
  endtask

  // Memory path seen mid-cycle, after inputs settle
  task automatic mem_path(input logic open);
    @(negedge CLK_IN);
    #1;
    check(MEM_REQ_OUT.valid, open);
    check(LOC_MST_RDY_OUT, open & MEM_RDY_IN);
    check(LOC_MST_RDATA_OUT, MEM_RDATA_IN);
    check(MEM_REQ_OUT.addr, LOC_MST_REQ_IN.addr);
    check(MEM_REQ_OUT.wdata, LOC_MST_REQ_IN.wdata);
    check({MEM_REQ_OUT.write, MEM_REQ_OUT.be}, {LOC_MST_REQ_IN.write, LOC_MST_REQ_IN.be});
    // Realign so the next stimulus lands on a falling edge
    @(negedge CLK_IN);
  endtask

  // Memory side and local master change every cycle
  always @(negedge CLK_IN) begin
    mr = rnd();
    MEM_RDY_IN <= mr[0];
    MEM_RDATA_IN <= {mr, ~mr};
    LOC_MST_REQ_IN <= '{1'b1, mr[1], mr, {~mr, mr}, mr[15:8]};
  end

  // Oldest note popped at each completed access, matched for reads only
  always @(negedge CLK_IN) begin
    if (SYS_RDY_OUT === 1'b1) begin
      if (notes.size() == 0) check(1'b1, 1'b0);
      else begin
        note = notes.pop_front();
        if (note[64]) check(SYS_RDATA_OUT, note[63:0]);
      end
    end
  end

  // Each accepted local word checked against the held request; low half first unless only high lanes are enabled
  always @(negedge CLK_IN) begin
    if (LOC_RDY_IN === 1'b1) begin
      exp_hi = mid | (SYS_REQ_IN.be[3:0] == 4'h0 && SYS_REQ_IN.be[7:4] != 4'h0);
      check(LOC_REQ_OUT.addr, {SYS_REQ_IN.addr[31:3], exp_hi, 2'b00});
      check(LOC_REQ_OUT.wdata, exp_hi ? SYS_REQ_IN.wdata[63:32] : SYS_REQ_IN.wdata[31:0]);
      check({LOC_REQ_OUT.valid, LOC_REQ_OUT.write, LOC_REQ_OUT.be},
            {1'b1, SYS_REQ_IN.write, exp_hi ? SYS_REQ_IN.be[7:4] : SYS_REQ_IN.be[3:0]});
      mid = !exp_hi && (SYS_REQ_IN.be[7:4] != 4'h0);
    end
  end

  task automatic run_access();
    logic [31:0] r;
    for (int i = 0; i < 12; i++) begin
      slow = i[0];
      r = rnd();
      sys_access(i % 3 == 2, rnd(), (i % 3 == 2) ? r[7:0] : 8'hff);
    end
    $display("access test done");
  endtask

  initial begin
    repeat (8) @(negedge CLK_IN);
    RST_B_IN = 1'b1;
    check(CPU_B, 1'b1);
    check(ACK_B, 1'b1);
    check(LOC_REQ_OUT.valid, 1'b0);
    check(SYS_RDY_OUT, 1'b0);
    mem_path(1'b0);
    run_access();
    // Start enable held asserted: no hold may start
    TSE_B <= 1'b0;
    LOC_HOLD_REQ_B_IN <= 1'b0;
    repeat (8) @(negedge CLK_IN);
    check(CPU_B, 1'b1);
    TSE_B <= 1'b1;
    wait_lvl(1'b0, 1'b0);
    check(ACK_B, 1'b1);
    wait_lvl(1'b1, 1'b0);
    mem_path(1'b1);
    // Processor access while held must be ignored
    SYS_REQ_IN <= '{1'b1, 1'b0, 32'h0, 64'h0, 8'hff};
    repeat (4) @(negedge CLK_IN);
    check(LOC_REQ_OUT.valid, 1'b0);
    check(SYS_RDY_OUT, 1'b0);
    SYS_REQ_IN.valid <= 1'b0;
    LOC_HOLD_REQ_B_IN <= 1'b1;
    wait_lvl(1'b1, 1'b1);
    check(CPU_B, 1'b1);
    repeat (6) @(negedge CLK_IN);
    mem_path(1'b0);
    $display("hold test done");
    run_access();
    check(notes.size(), 0);
    end_sim();
  end

  // Watchdog well past the expected few hundred cycles
  initial begin
    #40000;
    fail_count++;
    end_sim();
  end
endmodule
`default_nettype wire
